// [logic/cpusq_pkg.sv]
// Constants and types shared by the instruction sequencing core
// ----------------------------------------------------------------------------
// Operation
// - System clock splits into four phases; one pass is one instruction cycle.
// - Phase one increments the counter and fetches; phases two to four execute.
// - Fetch overlaps execution; counter-changing instructions cost one extra cycle.
// - Jumps and calls take two cycles: target obtained, then branch taken.
// - Counter advances by one per instruction unless a transfer is demanded.
// - Jumps, calls, interrupt entry and reset load the target directly.
// - A taken skip discards the prefetched instruction and runs a dummy cycle.
// - Only the counter low byte is software visible; writes stay in page.
// - Writing the counter low byte inserts one dummy cycle for prefetch.
// - Stack holds counter values only; stack and pointer are hidden from software.
// - Call and interrupt acknowledge push; both return kinds pop the counter.
// - Reset places the stack pointer at the top of the stack.
// - Interrupt with full stack stays pending until a return frees a level.
// - Call on a full stack still proceeds and loses the oldest entry.
// - Stack depth is a parameter: four or eight levels.
// - Eight-bit ALU writes the chosen destination and updates carry and flags.
// - Data moves through accumulator and ALU; special registers sit in data space.
// - ALU covers add, subtract, decimal adjust, logic, rotates, inc, dec, skips.
// ----------------------------------------------------------------------------
package cpusq_pkg;
    // ------------------------------------------------------------------------
    // Register bus map and reset values
    // ------------------------------------------------------------------------
    localparam logic [7:0] REG_PC_LOW = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam int CTRL_IEN_BIT = 0;
    localparam logic CTRL_IEN_RESET = 1'b1;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam int ST_C = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    // ------------------------------------------------------------------------
    // Data space special registers
    // ------------------------------------------------------------------------
    localparam logic [7:0] DM_IND = 8'h00;
    localparam logic [7:0] DM_PTR = 8'h01;
    localparam logic [7:0] DM_PC_LOW = 8'h02;
    localparam logic [7:0] DM_STATUS = 8'h03;
    localparam logic [7:0] DM_ACC = 8'h04;
    localparam logic [7:0] PTR_RESET = 8'h00;
    // ------------------------------------------------------------------------
    // Program space, instruction fields, variant defaults
    // ------------------------------------------------------------------------
    localparam int unsigned RESET_VECTOR = 0;
    localparam int unsigned INT_VECTOR_DEF = 4;
    localparam int PC_W_DEF = 11;
    localparam int STACK_DEPTH_DEF = 8;
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 11;
    localparam int DEST_BIT = 8;
    localparam logic [15:0] IR_RESET = 16'h0000;

    typedef enum logic [3:0] {
        PH_T1 = 4'b0001,
        PH_T2 = 4'b0010,
        PH_T3 = 4'b0100,
        PH_T4 = 4'b1000
    } cpusq_phase_t;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
        OP_SBC = 5'h04, OP_DECADJ = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
        OP_XOR = 5'h08, OP_COMPL = 5'h09, OP_RR = 5'h0A, OP_RORC = 5'h0B,
        OP_RL = 5'h0C, OP_ROLC = 5'h0D, OP_INC = 5'h0E, OP_DEC = 5'h0F,
        OP_SKZ = 5'h10, OP_SNZ = 5'h11, OP_INCSKZ = 5'h12, OP_DECSKZ = 5'h13,
        OP_MOVA = 5'h14, OP_MOVM = 5'h15, OP_LDI = 5'h16, OP_JUMP = 5'h17,
        OP_CALL = 5'h18, OP_RETURN = 5'h19, OP_IRET = 5'h1A
    } cpusq_op_t;
endpackage

// [logic/cpusq_core.sv]
// Instruction sequencer, return stack and ALU with AHB-Lite register access
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
module cpusq_core
    import cpusq_pkg::*;
#(
    parameter int PCW = PC_W_DEF,
    parameter int DEPTH = STACK_DEPTH_DEF,
    parameter int unsigned INT_VEC = INT_VECTOR_DEF
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [PCW-1:0] pm_addr,
    input wire logic [15:0] pm_rdata,
    output logic [7:0] dm_addr,
    input wire logic [7:0] dm_rdata,
    output logic [7:0] dm_wdata,
    output logic dm_we,
    input wire logic int_event,
    output logic int_ack,
    output logic [3:0] cycle_phases
);
    localparam int TPW = $clog2(DEPTH);
    localparam int CNTW = TPW + 1;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    cpusq_phase_t phase;
    logic [PCW-1:0] pc;
    logic [PCW-1:0] seq_pc;
    logic [PCW-1:0] next_pc;
    logic [15:0] prefetch;
    logic [15:0] ir;
    logic ir_valid;
    cpusq_op_t op;
    logic to_mem;
    logic [7:0] acc;
    logic [3:0] status;
    logic [3:0] next_status;
    logic [7:0] ptr;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [7:0] int_val;
    logic int_hit;
    logic [PCW-1:0] stk [DEPTH];
    logic [TPW-1:0] tp;
    logic [CNTW-1:0] cnt;
    logic stack_full;
    logic push;
    logic pop;
    logic int_pending;
    logic int_take;
    logic ctrl_ien;
    logic ahb_low_pend;
    logic [7:0] ahb_low_val;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic addr_ok;
    logic is_ar;
    logic is_sub;
    logic cyin;
    logic dst;
    logic upd_z;
    logic new_c;
    logic ovf;
    logic [7:0] bop;
    logic [8:0] sum;
    logic [4:0] hsum;
    logic [8:0] d1;
    logic [8:0] d2;
    logic wr_acc;
    logic wr_mem;
    logic skip_taken;
    logic jmp_now;
    logic ret_now;
    logic lowb_wr_now;
    logic instr_redirect;
    logic ahb_low_take;
    logic flush;
    logic commit;

    // ------------------------------------------------------------------------
    // Phase generator
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            phase <= PH_T1;
        else
            unique case (phase)
                PH_T1: phase <= PH_T2;
                PH_T2: phase <= PH_T3;
                PH_T3: phase <= PH_T4;
                PH_T4: phase <= PH_T1;
            endcase
    end

    assign cycle_phases = phase;
    assign commit = (phase == PH_T4);

    sequence s_four_phase;
        (phase == PH_T2) ##1 (phase == PH_T3) ##1 (phase == PH_T4) ##1 (phase == PH_T1);
    endsequence
    property p_phase_cycle;
        (phase == PH_T1) |=> s_four_phase;
    endproperty
    a_phase_cycle: assert property (p_phase_cycle) else $error("phase order broken");

    // ------------------------------------------------------------------------
    // Program counter and fetch pipeline
    // ------------------------------------------------------------------------
    assign pm_addr = pc;
    assign seq_pc = pc - PCW'(1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pc <= PCW'(RESET_VECTOR);
        else if (phase == PH_T1)
            pc <= pc + PCW'(1);
        else if (commit)
            pc <= next_pc;
    end

    // Prefetch in T1 while the previous word executes in T2 to T4
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prefetch <= IR_RESET;
            ir <= IR_RESET;
            ir_valid <= 1'b0;
        end
        else if (phase == PH_T1)
            prefetch <= pm_rdata;
        else if (commit)
        begin
            ir <= prefetch;
            ir_valid <= !flush;
        end
    end

    assign op = cpusq_op_t'(ir[OP_MSB:OP_LSB]);
    assign to_mem = ir[DEST_BIT];
    assign jmp_now = ir_valid && (op inside {OP_JUMP, OP_CALL});
    assign ret_now = ir_valid && (op inside {OP_RETURN, OP_IRET});
    assign lowb_wr_now = wr_mem && (dm_addr == DM_PC_LOW);
    assign instr_redirect = jmp_now || ret_now || lowb_wr_now || skip_taken;
    assign ahb_low_take = ahb_low_pend && !instr_redirect;
    assign int_take = int_pending && ctrl_ien && !stack_full && !instr_redirect
                      && !ahb_low_pend;
    assign flush = instr_redirect || ahb_low_take || int_take;

    // A skip keeps pc: it already points past the discarded word
    always_comb
    begin
        next_pc = pc;
        if (jmp_now)
            next_pc = ir[PCW-1:0];
        else if (ret_now)
            next_pc = stk[tp];
        else if (lowb_wr_now)
            next_pc = {seq_pc[PCW-1:8], res};
        else if (ahb_low_take)
            next_pc = {seq_pc[PCW-1:8], ahb_low_val};
        else if (int_take)
            next_pc = PCW'(INT_VEC);
    end

    property p_pc_step;
        (phase == PH_T1) |=> (pc == $past(pc) + PCW'(1));
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("counter did not step");

    sequence s_dummy_cycle;
        (!ir_valid) [*4];
    endsequence
    // A bus or interrupt redirect may claim the dummy slot and stretch the gap
    property p_jump_two;
        (commit && ir_valid && op == OP_JUMP) |=> (pc == $past(ir[PCW-1:0]))
            ##0 s_dummy_cycle ##1 (ir_valid || $past(ahb_low_take || int_take));
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

    property p_skip_dummy;
        (commit && skip_taken) |=> (pc == $past(pc)) ##0 s_dummy_cycle;
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) else $error("skip left no dummy");

    property p_low_page;
        (commit && lowb_wr_now) |=> (pc == {$past(seq_pc[PCW-1:8]), $past(res)})
            ##0 s_dummy_cycle;
    endproperty
    a_low_page: assert property (p_low_page) else $error("low byte jump wrong");

    property p_ahb_low_dummy;
        (commit && ahb_low_take) |=> (pc[7:0] == $past(ahb_low_val)) ##0 s_dummy_cycle;
    endproperty
    a_ahb_low_dummy: assert property (p_ahb_low_dummy) else $error("no prefetch gap");

    // ------------------------------------------------------------------------
    // Return stack: a ring, so an overflowing push overwrites the oldest level
    // ------------------------------------------------------------------------
    assign stack_full = (cnt == CNTW'(DEPTH));
    assign push = commit && ((ir_valid && op == OP_CALL) || int_take);
    assign pop = commit && ret_now;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tp <= '0;
            cnt <= '0;
        end
        else if (push)
        begin
            tp <= tp + TPW'(1);
            cnt <= stack_full ? cnt : cnt + CNTW'(1);
        end
        else if (pop)
        begin
            tp <= tp - TPW'(1);
            cnt <= (cnt == '0) ? cnt : cnt - CNTW'(1);
        end
    end

    // Contents need no reset; only the pointer and the level count carry meaning
    always_ff @(posedge hclk)
    begin
        if (push)
            stk[tp + TPW'(1)] <= seq_pc;
    end

    property p_push_value;
        push |=> (stk[tp] == $past(seq_pc));
    endproperty
    a_push_value: assert property (p_push_value) else $error("stack push lost");

    property p_call_full;
        (commit && ir_valid && op == OP_CALL && stack_full) |=> stack_full
            && (pc == $past(ir[PCW-1:0]));
    endproperty
    a_call_full: assert property (p_call_full) else $error("full call stalled");

    // ------------------------------------------------------------------------
    // Interrupt acknowledge
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            int_pending <= 1'b0;
            int_ack <= 1'b0;
        end
        else
        begin
            int_pending <= int_event || (int_pending && !(commit && int_take));
            int_ack <= commit && int_take;
        end
    end

    property p_int_hold;
        (int_pending && stack_full) |=> !int_ack;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("ack on full stack");

    // ------------------------------------------------------------------------
    // Operand path through the data space
    // ------------------------------------------------------------------------
    assign int_hit = (dm_addr <= DM_ACC);

    always_comb
    begin
        int_val = 8'h00;
        unique case (dm_addr)
            DM_PTR: int_val = ptr;
            DM_PC_LOW: int_val = seq_pc[7:0];
            DM_STATUS: int_val = {4'h0, status};
            DM_ACC: int_val = acc;
            default: int_val = 8'h00;
        endcase
    end

    // Indirect access resolves through the pointer once per cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dm_addr <= 8'h00;
            opnd <= 8'h00;
            dm_we <= 1'b0;
            dm_wdata <= 8'h00;
        end
        else
        begin
            if (phase == PH_T1)
                dm_addr <= (ir[7:0] == DM_IND) ? ptr : ir[7:0];
            if (phase == PH_T3)
                opnd <= int_hit ? int_val : dm_rdata;
            dm_we <= commit && wr_mem && !int_hit;
            if (commit && wr_mem)
                dm_wdata <= res;
        end
    end

    // ------------------------------------------------------------------------
    // ALU
    // ------------------------------------------------------------------------
    assign is_ar = op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC};
    assign is_sub = op inside {OP_SUB, OP_SBC};
    assign cyin = (op == OP_ADD) ? 1'b0 : (op == OP_SUB) ? 1'b1 : status[ST_C];
    assign bop = is_sub ? ~opnd : opnd;
    assign sum = 9'(acc) + 9'(bop) + 9'(cyin);
    assign hsum = 5'(acc[3:0]) + 5'(bop[3:0]) + 5'(cyin);
    assign ovf = (acc[7] == bop[7]) && (sum[7] != acc[7]);
    assign d1 = 9'(acc) + (((acc[3:0] > 4'h9) || status[ST_AC]) ? 9'h006 : 9'h000);
    assign d2 = d1 + (((d1[7:4] > 4'h9) || status[ST_C] || d1[8]) ? 9'h060 : 9'h000);
    assign dst = is_ar || (op inside {OP_DECADJ, OP_AND, OP_OR, OP_XOR, OP_COMPL, OP_RR,
                 OP_RORC, OP_RL, OP_ROLC, OP_INC, OP_DEC, OP_INCSKZ, OP_DECSKZ});
    assign upd_z = is_ar || (op inside {OP_AND, OP_OR, OP_XOR, OP_COMPL, OP_INC, OP_DEC});
    assign wr_acc = ir_valid && ((dst && !to_mem) || (op inside {OP_MOVA, OP_LDI}));
    assign wr_mem = ir_valid && ((dst && to_mem) || op == OP_MOVM);

    always_comb
    begin
        res = opnd;
        unique case (op)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC: res = sum[7:0];
            OP_DECADJ: res = d2[7:0];
            OP_AND: res = acc & opnd;
            OP_OR: res = acc | opnd;
            OP_XOR: res = acc ^ opnd;
            OP_COMPL: res = ~opnd;
            OP_RR: res = {opnd[0], opnd[7:1]};
            OP_RORC: res = {status[ST_C], opnd[7:1]};
            OP_RL: res = {opnd[6:0], opnd[7]};
            OP_ROLC: res = {opnd[6:0], status[ST_C]};
            OP_INC, OP_INCSKZ: res = opnd + 8'h01;
            OP_DEC, OP_DECSKZ: res = opnd - 8'h01;
            OP_MOVM: res = acc;
            OP_LDI: res = ir[7:0];
            default: res = opnd;
        endcase
    end

    // Subtract carry is set when no borrow occurs
    assign new_c = is_ar ? sum[8]
                 : (op == OP_DECADJ) ? (status[ST_C] | d1[8] | d2[8])
                 : (op == OP_RORC) ? opnd[0]
                 : (op == OP_ROLC) ? opnd[7]
                 : status[ST_C];
    assign next_status = {is_ar ? ovf : status[ST_OV],
                          upd_z ? (res == 8'h00) : status[ST_Z],
                          is_ar ? hsum[4] : status[ST_AC],
                          new_c};
    assign skip_taken = ir_valid && (((op == OP_SKZ) && (opnd == 8'h00))
                      || ((op == OP_SNZ) && (opnd != 8'h00))
                      || ((op inside {OP_INCSKZ, OP_DECSKZ}) && (res == 8'h00)));

    // A write aimed at the status register overrides the flag update
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc <= ACC_RESET;
            status <= STATUS_RESET;
            ptr <= PTR_RESET;
        end
        else if (commit && ir_valid)
        begin
            if (wr_acc || (wr_mem && dm_addr == DM_ACC))
                acc <= res;
            if (wr_mem && dm_addr == DM_STATUS)
                status <= res[3:0];
            else
                status <= next_status;
            if (wr_mem && dm_addr == DM_PTR)
                ptr <= res;
        end
    end

    property p_acc_dest;
        (commit && wr_acc && op != OP_MOVA) |=> (acc == $past(res)) && !dm_we;
    endproperty
    a_acc_dest: assert property (p_acc_dest) else $error("accumulator not loaded");

    property p_mem_dest;
        (commit && wr_mem && !int_hit) |=> dm_we && (dm_wdata == $past(res))
            && (dm_addr == $past(dm_addr));
    endproperty
    a_mem_dest: assert property (p_mem_dest) else $error("memory write lost");

    // ------------------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ------------------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            hrdata <= 32'h00000000;
        end
        else
        begin
            dp_valid <= addr_ok;
            if (addr_ok)
            begin
                dp_write <= hwrite;
                dp_addr <= haddr[7:0];
            end
            if (addr_ok && !hwrite)
                unique case (haddr[7:0])
                    REG_PC_LOW: hrdata <= {24'h000000, seq_pc[7:0]};
                    REG_ACC: hrdata <= {24'h000000, acc};
                    REG_STATUS: hrdata <= {28'h0000000, status};
                    REG_CTRL: hrdata <= {31'h00000000, ctrl_ien};
                    default: hrdata <= 32'h00000000;
                endcase
        end
    end

    // A bus write to the low byte waits for a commit without an instruction redirect; set wins over clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ien <= CTRL_IEN_RESET;
            ahb_low_pend <= 1'b0;
            ahb_low_val <= 8'h00;
        end
        else
        begin
            if (dp_valid && dp_write && dp_addr == REG_CTRL)
                ctrl_ien <= hwdata[CTRL_IEN_BIT];
            if (dp_valid && dp_write && dp_addr == REG_PC_LOW)
            begin
                ahb_low_pend <= 1'b1;
                ahb_low_val <= hwdata[7:0];
            end
            else if (commit && ahb_low_take)
                ahb_low_pend <= 1'b0;
        end
    end
endmodule

// [test/cpusq_mem_model.sv]
// Program and data memory model facing the sequencing core
module cpusq_mem_model #(
    parameter int PCW = 10,
    parameter bit SLOW = 1'b1
)
(
    input wire logic hclk,
    input wire logic [PCW-1:0] pm_addr,
    output logic [15:0] pm_rdata,
    input wire logic [7:0] dm_addr,
    output logic [7:0] dm_rdata,
    input wire logic [7:0] dm_wdata,
    input wire logic dm_we
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pm [2**PCW];
    logic [7:0] dm [256];
    logic [7:0] rd_q;
    // Slow mode answers a clock late, the latest the core tolerates
    always @(posedge hclk)
    begin
        rd_q <= dm[dm_addr];
        if (dm_we)
        begin
            dm[dm_addr] <= dm_wdata;
        end
    end
    assign pm_rdata = pm[pm_addr];
    assign dm_rdata = SLOW ? rd_q : dm[dm_addr];
endmodule

// [test/tb_top.sv]
// Self-checking bench for the sequencing core
module tb_top import cpusq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Signals
    // ----
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic int_event = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, dm_we, int_ack;
    logic [9:0] pm_addr;
    logic [15:0] pm_rdata;
    logic [7:0] dm_addr, dm_rdata, dm_wdata;
    logic [3:0] cycle_phases;
    int bad_count = 0, n_tests = 0, cyc = 0, ack_n = 0, seen131 = 0;
    always #2.5 hclk = ~hclk;
    cpusq_core #(.PCW(10), .DEPTH(4), .INT_VEC(4)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
        .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we), .int_event(int_event),
        .int_ack(int_ack), .cycle_phases(cycle_phases));
    cpusq_mem_model #(.PCW(10), .SLOW(1'b1)) mem (.hclk(hclk), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_rdata(dm_rdata),
        .dm_wdata(dm_wdata), .dm_we(dm_we));
    // ----
    // Monitors and watchdog
    // ----
    always @(posedge hclk)
    begin
        cyc++;
        if (int_ack === 1'b1)
            ack_n++;
        if (cycle_phases === PH_T1 && pm_addr === 10'h131)
            seen131++;
        if (cyc == 5000)
        begin
            bad_count++;
            final_report();
        end
    end
    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Clocks until a fetch phase shows the given address
    task automatic fetch(input logic [9:0] a, output int n);
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (!(cycle_phases === PH_T1 && pm_addr === a) && n < 400);
    endtask
    task automatic p(input logic [9:0] a, input cpusq_op_t op, input logic [9:0] x);
        mem.pm[a] = {op, 11'h000} | {6'h00, x};
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        logic [3:0] ph;
        int n;
        ph = 4'h1;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8)
        begin
            @(posedge hclk);
            chk(cycle_phases, ph);
            ph = {ph[2:0], ph[3]};
        end
        fetch(10'h108, n);
        chk(n, 1);
        ahb(1'b0, REG_ACC, 32'h0);
        chk(rd, ACC_RESET);
        ahb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        ahb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_seq();
        int n;
        fetch(10'h10C, n);
        fetch(10'h10D, n);
        chk(n, 4);
        fetch(10'h10D, n);
        chk(n, 8);
        ahb(1'b0, REG_ACC, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, REG_STATUS, 32'h0);
        chk(rd & 32'h5, 32'h5);
        chk(mem.dm[8'h12], 8'h00);
    endtask
    task automatic t_page_jump();
        int n;
        ahb(1'b1, REG_PC_LOW, 32'h30);
        fetch(10'h130, n);
        chk(n < 40, 1'b1);
    endtask
    // Five nested calls on a four-deep stack, then a held interrupt
    task automatic t_stack();
        int n, a0, s0;
        fetch(10'h190, n);
        chk(n < 80, 1'b1);
        a0 = ack_n;
        int_event <= 1'b1;
        @(posedge hclk);
        int_event <= 1'b0;
        repeat (40) @(posedge hclk);
        chk(ack_n - a0, 0);
        ahb(1'b1, REG_PC_LOW, 32'h91);
        fetch(10'h004, n);
        @(posedge hclk);
        chk(ack_n - a0, 1);
        fetch(10'h182, n);
        // The load at 181 commits at the end of this instruction cycle
        repeat (4) @(posedge hclk);
        ahb(1'b0, REG_ACC, 32'h0);
        chk(rd, 32'h81);
        s0 = seen131;
        ahb(1'b1, REG_PC_LOW, 32'h83);
        repeat (200) @(posedge hclk);
        chk(seen131 - s0, 0);
    endtask
    // An instruction write to the low byte jumps in page behind a dummy cycle
    task automatic t_instr_jump();
        int n;
        ahb(1'b1, REG_PC_LOW, 32'hA0);
        fetch(10'h1A9, n);
        chk(n < 80, 1'b1);
        repeat (4) @(posedge hclk);
        ahb(1'b0, REG_ACC, 32'h0);
        chk(rd, 32'h5A);
    endtask
    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        for (int i = 0; i < 1024; i++)
            mem.pm[i] = 16'h0000;
        mem.dm[8'h10] = 8'hFB;
        mem.dm[8'h11] = 8'h00;
        mem.dm[8'h12] = 8'hEE;
        p(10'h000, OP_JUMP, 10'h108);
        p(10'h004, OP_IRET, 10'h000);
        p(10'h108, OP_LDI, 10'h005);
        p(10'h109, OP_ADD, 10'h010);
        p(10'h10A, OP_SKZ, 10'h011);
        p(10'h10B, OP_LDI, 10'h0AA);
        p(10'h10C, OP_MOVM, 10'h112);
        p(10'h10D, OP_JUMP, 10'h10D);
        p(10'h130, OP_CALL, 10'h150);
        p(10'h131, OP_LDI, 10'h031);
        p(10'h150, OP_CALL, 10'h160);
        p(10'h151, OP_RETURN, 10'h000);
        p(10'h160, OP_CALL, 10'h170);
        p(10'h161, OP_RETURN, 10'h000);
        p(10'h170, OP_CALL, 10'h180);
        p(10'h171, OP_RETURN, 10'h000);
        p(10'h180, OP_CALL, 10'h190);
        p(10'h181, OP_LDI, 10'h081);
        p(10'h182, OP_JUMP, 10'h182);
        p(10'h183, OP_RETURN, 10'h000);
        p(10'h190, OP_JUMP, 10'h190);
        p(10'h191, OP_RETURN, 10'h000);
        // A trap at 1A2 catches a missing dummy cycle
        p(10'h1A0, OP_LDI, 10'h0A8);
        p(10'h1A1, OP_MOVM, 10'h102);
        p(10'h1A2, OP_JUMP, 10'h1A2);
        p(10'h1A8, OP_LDI, 10'h05A);
        p(10'h1A9, OP_JUMP, 10'h1A9);
        t_reset();
        t_seq();
        t_page_jump();
        t_stack();
        t_instr_jump();
        final_report();
    end
endmodule
